// file: src/ocmp_pkg.sv
// constants and types for the output compare mode engine
package ocmp_pkg;
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_PRIMARY = 12'h004;
  localparam logic [11:0] ADDR_SECONDARY = 12'h008;
  localparam logic [11:0] ADDR_TIMER = 12'h00c;
  localparam logic [11:0] ADDR_PERIOD = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_ONE_RISE = 3'b001,
    MODE_ONE_FALL = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_DBL_ONE = 3'b100,
    MODE_DBL_CONT = 3'b101,
    MODE_PWM_EDGE = 3'b110,
    MODE_PWM_CENTER = 3'b111
  } mode_t;

  // one-shot and double-compare sequencing; gray codes along the double-compare path
  typedef enum logic [1:0] {
    SEQ_WAIT_PRI = 2'b00,
    SEQ_WAIT_SEC = 2'b01,
    SEQ_DONE = 2'b11
  } seq_t;

  typedef struct packed {
    logic [15:0] primary;
    logic [15:0] secondary;
  } cmp_pair_t;
endpackage

// file: src/output_compare_mode_engine.sv
// apb-attached output compare channel with timer, modes and pin driver
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module output_compare_mode_engine #(
  parameter int TW = 16
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic COMPARE_OUTPUT_PIN
);
  // register file
  logic [15:0] control;
  logic [15:0] next_control;
  ocmp_pkg::cmp_pair_t shadow;
  ocmp_pkg::cmp_pair_t next_shadow;
  logic [15:0] period;
  logic [15:0] next_period;

  // timer and the compare pair in use
  ocmp_pkg::cmp_pair_t active;
  ocmp_pkg::cmp_pair_t next_active;
  logic [TW-1:0] compare_timer;
  logic [TW-1:0] next_compare_timer;

  // pin state
  logic pin;
  logic next_pin;
  ocmp_pkg::seq_t seq;
  ocmp_pkg::seq_t next_seq;
  logic [2:0] prev_mode;
  logic [2:0] next_prev_mode;
  logic init_pin;

  // bus answer
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  ocmp_pkg::mode_t mode;
  logic is_pwm;
  logic mode_change;
  logic pwm_load;
  logic wr;
  logic rd;
  logic restart;
  logic [1:0] hit;
  logic hit_pri;
  logic hit_sec;
  logic hit_zero;
  logic one_shot_done;
  logic [31:0] status_word;
  logic [15:0] wmask;
  logic [15:0] tmr16;

  assign mode = ocmp_pkg::mode_t'(control[ocmp_pkg::MODE_LSB +: ocmp_pkg::MODE_W]);
  assign is_pwm = (mode == ocmp_pkg::MODE_PWM_EDGE) || (mode == ocmp_pkg::MODE_PWM_CENTER);
  assign mode_change = (prev_mode != control[2:0]);
  // pwm pairs load on entry and at each wrap, so a period never mixes old and new
  assign pwm_load = restart || mode_change;
  // two-cycle access phase: the answer comes in the second penable cycle
  assign wr = PSEL && PENABLE && PWRITE && !PREADY;
  assign rd = PSEL && PENABLE && !PWRITE && !PREADY;
  // only lanes 0 and 1 carry register bits; lanes 2 and 3 are ignored
  for (genvar b = 0; b < 2; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{PSTRB[b]}};
  end
  assign tmr16 = 16'(compare_timer);
  // a period written below the running count wraps at once
  assign restart = (tmr16 >= period);
  // one comparator per compare value: 0 primary, 1 secondary
  for (genvar c = 0; c < 2; c++) begin : g_cmp
    assign hit[c] = (tmr16 == active[16*(1-c) +: 16]);
  end
  assign hit_pri = hit[0];
  assign hit_sec = hit[1];
  assign hit_zero = (tmr16 == 16'h0000);
  assign one_shot_done = (seq == ocmp_pkg::SEQ_DONE);
  assign status_word = {30'h0000_0000, one_shot_done, pin};

  // read and write answer: one wait state; data and error stand with ready
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (wr || rd) begin
      next_pready = 1'b1;
      unique case (PADDR)
        ocmp_pkg::ADDR_CONTROL: begin
          next_prdata = {16'h0000, control};
        end
        ocmp_pkg::ADDR_PRIMARY: begin
          next_prdata = {16'h0000, shadow.primary};
        end
        ocmp_pkg::ADDR_SECONDARY: begin
          next_prdata = {16'h0000, shadow.secondary};
        end
        ocmp_pkg::ADDR_TIMER: begin
          next_prdata = {16'h0000, tmr16};
        end
        ocmp_pkg::ADDR_PERIOD: begin
          next_prdata = {16'h0000, period};
        end
        ocmp_pkg::ADDR_STATUS: begin
          next_prdata = status_word;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // register writes; byte lanes merge under the write mask
  always_comb begin
    next_control = control;
    next_period = period;
    next_shadow = shadow;
    if (wr) begin
      unique case (PADDR)
        ocmp_pkg::ADDR_CONTROL: begin
          next_control = (control & ~wmask) | (PWDATA[15:0] & wmask);
        end
        ocmp_pkg::ADDR_PRIMARY: begin
          next_shadow.primary = (shadow.primary & ~wmask) | (PWDATA[15:0] & wmask);
        end
        ocmp_pkg::ADDR_SECONDARY: begin
          next_shadow.secondary = (shadow.secondary & ~wmask) | (PWDATA[15:0] & wmask);
        end
        ocmp_pkg::ADDR_PERIOD: begin
          next_period = (period & ~wmask) | (PWDATA[15:0] & wmask);
        end
        ocmp_pkg::ADDR_TIMER, ocmp_pkg::ADDR_STATUS: begin
          // read-only: the write is dropped without an error
          next_control = control;
        end
        default: begin
          next_control = control;
        end
      endcase
    end
  end

  // timer and active compare values
  always_comb begin
    // the timer free-runs in every mode, disabled included
    next_compare_timer = restart ? '0 : compare_timer + 1'b1;
    next_active = active;
    if (!is_pwm) begin
      next_active = next_shadow;
    end else if (pwm_load) begin
      // loading at wrap keeps one period's pair consistent
      next_active = shadow;
    end
  end

  // level each mode starts from when it is entered
  always_comb begin
    init_pin = pin;
    unique case (mode)
      ocmp_pkg::MODE_ONE_FALL: begin
        init_pin = 1'b1;
      end
      ocmp_pkg::MODE_ONE_RISE: begin
        init_pin = 1'b0;
      end
      ocmp_pkg::MODE_DBL_ONE: begin
        init_pin = 1'b0;
      end
      ocmp_pkg::MODE_DBL_CONT: begin
        init_pin = 1'b0;
      end
      default: begin
        init_pin = pin;
      end
    endcase
  end

  // pin and sequencing
  always_comb begin
    next_pin = pin;
    next_seq = seq;
    next_prev_mode = control[2:0];
    if (mode_change) begin
      // the entry cycle only re-initialises; a match in it is lost
      next_seq = ocmp_pkg::SEQ_WAIT_PRI;
      next_pin = init_pin;
    end else begin
      unique case (mode)
        ocmp_pkg::MODE_OFF: begin
          // a disabled channel keeps its last level rather than glitching
          next_pin = pin;
        end
        ocmp_pkg::MODE_ONE_RISE: begin
          // one-shots fire once per entry; writing another mode rearms them
          if (hit_pri && seq == ocmp_pkg::SEQ_WAIT_PRI) begin
            next_pin = 1'b1;
            next_seq = ocmp_pkg::SEQ_DONE;
          end
        end
        ocmp_pkg::MODE_ONE_FALL: begin
          if (hit_pri && seq == ocmp_pkg::SEQ_WAIT_PRI) begin
            next_pin = 1'b0;
            next_seq = ocmp_pkg::SEQ_DONE;
          end
        end
        ocmp_pkg::MODE_TOGGLE: begin
          if (hit_pri) begin
            next_pin = !pin;
          end
        end
        ocmp_pkg::MODE_DBL_ONE, ocmp_pkg::MODE_DBL_CONT: begin
          if (seq == ocmp_pkg::SEQ_WAIT_PRI && hit_pri) begin
            next_pin = !pin;
            next_seq = ocmp_pkg::SEQ_WAIT_SEC;
          end else if (seq == ocmp_pkg::SEQ_WAIT_SEC && hit_sec) begin
            next_pin = !pin;
            next_seq = (mode == ocmp_pkg::MODE_DBL_CONT) ? ocmp_pkg::SEQ_WAIT_PRI
                                                          : ocmp_pkg::SEQ_DONE;
          end
        end
        ocmp_pkg::MODE_PWM_EDGE: begin
          // zero wins over a primary of zero, so that setting holds the pin high
          if (hit_pri && !hit_zero) begin
            next_pin = 1'b0;
          end else if (hit_zero) begin
            next_pin = 1'b1;
          end
        end
        ocmp_pkg::MODE_PWM_CENTER: begin
          if (hit_sec) begin
            next_pin = 1'b0;
          end else if (hit_pri) begin
            next_pin = 1'b1;
          end
        end
      endcase
    end
  end

  // answer registers: ready, data and error stand one cycle together
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      // reset leaves the channel disabled with the period at its top
      control <= ocmp_pkg::CONTROL_RESET;
      period <= ocmp_pkg::PERIOD_RESET;
      shadow <= '{primary: ocmp_pkg::VALUE_RESET, secondary: ocmp_pkg::VALUE_RESET};
    end else begin
      control <= next_control;
      period <= next_period;
      shadow <= next_shadow;
    end
  end

  // timer group
  always_ff @(posedge CLK) begin
    if (SRST) begin
      active <= '{primary: ocmp_pkg::VALUE_RESET, secondary: ocmp_pkg::VALUE_RESET};
      compare_timer <= '0;
    end else begin
      active <= next_active;
      compare_timer <= next_compare_timer;
    end
  end

  // pin group
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pin <= 1'b0;
      seq <= ocmp_pkg::SEQ_WAIT_PRI;
      prev_mode <= 3'b000;
    end else begin
      pin <= next_pin;
      seq <= next_seq;
      prev_mode <= next_prev_mode;
    end
  end

  assign COMPARE_OUTPUT_PIN = pin;
endmodule
`default_nettype wire

// file: tb/ocmp_load.sv
// load on the compare pin: counts rising edges it sees
`timescale 1ns/1ps
`default_nettype none
module ocmp_load (
  input wire logic clk,
  input wire logic pin,
  output logic [15:0] rises,
  output logic [15:0] highs
);
  logic last = 1'b0;
  logic [15:0] n_rise = 16'h0;
  logic [15:0] n_high = 16'h0;
  always @(posedge clk) begin
    if (pin && !last) n_rise <= n_rise + 16'h1;
    if (pin) n_high <= n_high + 16'h1;
    last <= pin;
  end
  assign rises = n_rise;
  assign highs = n_high;
endmodule
`default_nettype wire

// file: tb/ocmp_properties.sv
// checker for bus timing and pin mode behaviour
`timescale 1ns/1ps
`default_nettype none
module ocmp_properties (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic COMPARE_OUTPUT_PIN
);
  logic [2:0] md;
  logic [2:0] next_md;
  // mirrors the mode field at the edge the write is taken
  always_comb begin
    next_md = md;
    if (PSEL && PENABLE && !PREADY && PWRITE && PADDR == 12'h000) next_md = PWDATA[2:0];
    if (SRST) next_md = 3'h0;
  end
  always_ff @(posedge CLK) md <= next_md;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("late");
  a_ready_phase: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready out of phase");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
  a_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("bad err");
  a_off_hold: assert property (md == 3'h0 && $past(md) == 3'h0 |=> $stable(COMPARE_OUTPUT_PIN))
    else $error("pin moved while off");
  a_init_low: assert property ($changed(md) && md inside {3'h1, 3'h4, 3'h5} |=> !COMPARE_OUTPUT_PIN)
    else $error("no low init");
  a_init_high: assert property ($changed(md) && md == 3'h2 |=> COMPARE_OUTPUT_PIN)
    else $error("no high init");
  a_rise_keep: assert property (md == 3'h1 && $past(md) == 3'h1 && COMPARE_OUTPUT_PIN |=> COMPARE_OUTPUT_PIN)
    else $error("one-shot fell");
endmodule
bind output_compare_mode_engine ocmp_properties ocmp_properties_i (.*);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the output compare channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, pin;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [15:0] rises, r0, rnd = 16'hcf0d;
  logic [15:0] highs, h0;
  logic [3:0] PSTRB = 4'hf;
  logic [6:0] exp_h [8] = '{0, 64, 0, 32, 0, 20, 20, 20};
  logic [32:0] q[$];
  logic [2:0] exp_r [8] = '{0, 0, 0, 2, 0, 4, 4, 4};
  int n_mismatch = 0, checked = 0;
  always #2 CLK = ~CLK;
  output_compare_mode_engine output_compare_mode_engine_i (.CLK(CLK), .SRST(SRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .COMPARE_OUTPUT_PIN(pin));
  ocmp_load ocmp_load_i (.clk(CLK), .pin(pin), .rises(rises), .highs(highs));
  task bad(input string s);
    $display("BAD %0t %s", $time, s);
    n_mismatch++;
  endtask
  task cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) bad("read data");
  endtask
  task cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) bad("pin activity");
  endtask
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge CLK) if (PREADY === 1'b1 && !PWRITE) begin
    if (q.size() == 0) bad("extra read");
    else cmp_rd({PSLVERR, PRDATA}, q.pop_front());
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    if (!w) q.push_back(e);
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) bad("no ready");
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole run is near 910 cycles; allow over five times that
  initial begin
    #20000;
    bad("timeout");
    test_done;
  end
  initial begin
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
    apb(0, 12'h000, 0, 33'h0);
    apb(0, 12'h010, 0, 33'h0ffff);
    apb(0, 12'h020, 0, 33'h100000000);
    rnd = lfsr(rnd);
    apb(1, 12'h004, {16'h0, rnd}, 0);
    apb(0, 12'h004, 0, {17'h0, rnd});
    PSTRB <= 4'h2;
    apb(1, 12'h004, 32'h0000_a5a5, 0);
    PSTRB <= 4'hf;
    apb(0, 12'h004, 0, {17'h0, 8'ha5, rnd[7:0]});
    $display("registers done");
    apb(1, 12'h010, 32'hf, 0);
    apb(1, 12'h004, 32'h5, 0);
    apb(1, 12'h008, 32'ha, 0);
    // settle past any one-shot pulse, then count edges over four periods
    for (int m = 1; m < 9; m++) begin
      apb(1, 12'h000, 32'(m % 8), 0);
      repeat (40) @(posedge CLK);
      r0 = rises;
      h0 = highs;
      repeat (64) @(posedge CLK);
      cmp_pin(rises - r0, {13'h0, exp_r[m % 8]});
      if (m % 8 != 0) cmp_pin(highs - h0, {9'h0, exp_h[m % 8]});
      if (m inside {1, 2, 4}) cmp_pin({15'h0, pin}, {15'h0, m == 1});
      if (m == 1) apb(0, 12'h014, 0, 33'h3);
    end
    $display("modes done");
    test_done;
  end
endmodule
`default_nettype wire
